// >>> src/frame_readout_context_compand.v
// frame sequencer with two-context shadowed settings and 12-to-10 bit compander
//
// Contract
// - each frame emits its blanking rows first and then its active rows.
// - a frame lasts rows-per-frame rows, each of clocks-per-row clocks, each count raised to its minimum when set lower.
// - the first blanking row opens the frame and the last active row closes it.
// - the parallel side marks frames and rows with frame and row window flags.
// - serial codes follow the framing mode chosen (basic, framed, packet).
// - extra blanking rows stretch the frame but not the active readout span.
// - a setting written during frame n takes effect at the start of frame n+2.
// - two full setting sets exist and bit 13 of the context control picks one.
// - a context change in frame n moves exposure at n+1 and the rest at n+2.
// - exposure, row timing, binning, gains, window and steps are duplicated.
// - pixels may be compressed from 12 to 10 bits with a segmented law.
// - compression acts on the pixel after the pedestal has been added.
// - compression is off at reset and needs enable 1 plus the config key.
// - the compressor maps each input range to its fixed code segment.
// - blanking is at least the optical black row count plus eight rows.
`timescale 1ns/1ps
`include "frame_readout_map.vh"

module frame_readout_context_compand #(
  parameter NREG = 36,
  // reset frame geometry; smaller values give short frames for quick runs
  parameter [15:0] RESET_ROW_LAST = `RST_ROW_LAST,
  parameter [15:0] RESET_COL_LAST = `RST_COL_LAST,
  parameter [15:0] RESET_ROWS = `RST_ROWS_PER_FRAME,
  parameter [15:0] RESET_CLOCKS = `RST_CLOCKS_PER_ROW
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register port
  input wire reg_we_i,
  input wire reg_re_i,
  input wire [15:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  // pixel source
  input wire [11:0] pix_i,
  // pixel stream out
  output reg [11:0] pix_o,
  output reg pix_valid_o,
  output reg frame_window_flag_o,
  output reg row_window_flag_o,
  output reg [2:0] code_o,
  output reg code_valid_o,
  output reg frame_start_o,
  // settings in force
  output reg [15:0] exposure_rows_o,
  output reg [5:0] analog_gain_o,
  output reg [15:0] gain_overall_o,
  output reg context_o,
  output reg [1:0] bin_o
);

////////////////////////////////////////////////////////////////////////////////

  localparam [5:0] I_NONE = 6'h3F;

  function [5:0] reg_index;
    input [15:0] a;
    begin
      case (a)
        `A_ROW_FIRST_A: reg_index = 6'd0;
        `A_COL_FIRST_A: reg_index = 6'd1;
        `A_ROW_LAST_A: reg_index = 6'd2;
        `A_COL_LAST_A: reg_index = 6'd3;
        `A_ROWS_PER_FRAME_A: reg_index = 6'd4;
        `A_CLOCKS_PER_ROW_A: reg_index = 6'd5;
        `A_EXPOSURE_ROWS_A: reg_index = 6'd6;
        `A_EXPOSURE_ROWS_B: reg_index = 6'd7;
        `A_CLOCKS_PER_ROW_B: reg_index = 6'd8;
        `A_BINNING_SELECT_AB: reg_index = 6'd9;
        `A_GAIN_GREEN_FIRST_A: reg_index = 6'd10;
        `A_GAIN_BLUE_A: reg_index = 6'd11;
        `A_GAIN_RED_A: reg_index = 6'd12;
        `A_GAIN_GREEN_SECOND_A: reg_index = 6'd13;
        `A_GAIN_OVERALL_A: reg_index = 6'd14;
        `A_ANALOG_GAIN_AB: reg_index = 6'd15;
        `A_COL_FIRST_B: reg_index = 6'd16;
        `A_ROW_FIRST_B: reg_index = 6'd17;
        `A_COL_LAST_B: reg_index = 6'd18;
        `A_ROW_LAST_B: reg_index = 6'd19;
        `A_COL_STEP_A: reg_index = 6'd20;
        `A_ROW_STEP_A: reg_index = 6'd21;
        `A_ROW_STEP_B: reg_index = 6'd22;
        `A_ROWS_PER_FRAME_B: reg_index = 6'd23;
        `A_COL_STEP_B: reg_index = 6'd24;
        `A_GAIN_GREEN_FIRST_B: reg_index = 6'd25;
        `A_GAIN_BLUE_B: reg_index = 6'd26;
        `A_GAIN_RED_B: reg_index = 6'd27;
        `A_GAIN_GREEN_SECOND_B: reg_index = 6'd28;
        `A_GAIN_OVERALL_B: reg_index = 6'd29;
        `A_CONTEXT_CTRL: reg_index = 6'd30;
        `A_BLACK_ROWS: reg_index = 6'd31;
        `A_PEDESTAL: reg_index = 6'd32;
        `A_FRAMING_MODE: reg_index = 6'd33;
        `A_COMPAND_EN: reg_index = 6'd34;
        `A_COMPAND_CFG: reg_index = 6'd35;
        default: reg_index = I_NONE;
      endcase
    end
  endfunction

  // both contexts share one reset image
  function [15:0] reset_value;
    input integer i;
    begin
      case (i)
        2, 19: reset_value = RESET_ROW_LAST;
        3, 18: reset_value = RESET_COL_LAST;
        4, 23: reset_value = RESET_ROWS;
        5, 8: reset_value = RESET_CLOCKS;
        6, 7: reset_value = `RST_EXPOSURE;
        20, 21, 22, 24: reset_value = `RST_STEP;
        31: reset_value = `RST_BLACK_ROWS;
        default: reset_value = 16'h0000;
      endcase
    end
  endfunction

  function [15:0] pick;
    input sel_b;
    input [15:0] a;
    input [15:0] b;
    begin
      pick = sel_b ? b : a;
    end
  endfunction

  // a step of 3 halves the span (skip or bin by two)
  function [15:0] span;
    input [15:0] first;
    input [15:0] last;
    input [15:0] step;
    reg [15:0] d;
    begin
      d = last - first + 16'h0001;
      span = step[1] ? {1'b0, d[15:1]} : d;
    end
  endfunction

  function [9:0] compress;
    input [11:0] x;
    begin
      if (x[11])
        compress = {2'b11, x[10:3]};
      else if (x[10])
        compress = {2'b10, x[9:2]};
      else if (x[9])
        compress = {3'b011, x[8:2]};
      else if (x[8])
        compress = {3'b010, x[7:1]};
      else
        compress = {2'b00, x[7:0]};
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
// three copies: as written, latched one frame, in force

  reg [15:0] wr_q [0:NREG-1];
  reg [15:0] stage_q [0:NREG-1];
  reg [15:0] live_q [0:NREG-1];
  reg [15:0] row_q;
  reg [15:0] col_q;
  reg [15:0] frame_cnt_q;
  reg row_win_q;
  reg [5:0] wr_idx;
  reg [5:0] rd_idx;
  integer i;

  always @* begin
    wr_idx = reg_index(reg_addr_i);
    rd_idx = reg_index(reg_addr_i);
  end

  wire ctx_live = live_q[30][`CTX_BIT];
  wire ctx_stage = stage_q[30][`CTX_BIT];

  wire [15:0] row_first = pick(ctx_live, live_q[0], live_q[17]);
  wire [15:0] col_first = pick(ctx_live, live_q[1], live_q[16]);
  wire [15:0] row_last = pick(ctx_live, live_q[2], live_q[19]);
  wire [15:0] col_last = pick(ctx_live, live_q[3], live_q[18]);
  wire [15:0] rows_set = pick(ctx_live, live_q[4], live_q[23]);
  wire [15:0] clocks_set = pick(ctx_live, live_q[5], live_q[8]);
  wire [15:0] row_step = pick(ctx_live, live_q[21], live_q[22]);
  wire [15:0] col_step = pick(ctx_live, live_q[20], live_q[24]);
  wire [15:0] gain_all = pick(ctx_live, live_q[14], live_q[29]);
  wire [15:0] gain_reg = live_q[15];
  wire [15:0] bin_reg = live_q[9];

  // exposure follows the context one frame earlier than the rest
  wire [15:0] exposure = pick(ctx_stage, live_q[6], live_q[7]);

////////////////////////////////////////////////////////////////////////////////
// frame geometry

  wire [15:0] act_rows = span(row_first, row_last, row_step);
  wire [15:0] act_cols = span(col_first, col_last, col_step);
  wire [15:0] black_rows = {12'h000, live_q[31][`BLACK_LSB+3:`BLACK_LSB]};
  wire [15:0] min_blank = black_rows + `BLANK_EXTRA;
  wire [15:0] rows_min = act_rows + min_blank;
  wire [15:0] cols_min = act_cols + `ROW_TAIL;

  // too short a frame is stretched rather than losing active rows
  wire [15:0] rows_eff = (rows_set < rows_min) ? rows_min : rows_set;
  wire [15:0] clocks_eff = (clocks_set < cols_min) ? cols_min : clocks_set;
  wire [15:0] blank_rows = rows_eff - act_rows;

  wire last_col = (col_q == clocks_eff - 16'h0001);
  wire last_row = (row_q == rows_eff - 16'h0001);
  wire frame_end = last_col && last_row;
  wire in_active = (row_q >= blank_rows);
  wire [15:0] pix_end = `PIX_LEAD + act_cols;
  wire row_win = in_active && (col_q >= `PIX_LEAD) && (col_q < pix_end);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_q <= 16'h0000;
      col_q <= 16'h0000;
      frame_cnt_q <= 16'h0000;
    end else if (last_col) begin
      col_q <= 16'h0000;
      if (last_row) begin
        row_q <= 16'h0000;
        frame_cnt_q <= frame_cnt_q + 16'h0001;
      end else begin
        row_q <= row_q + 16'h0001;
      end
    end else begin
      col_q <= col_q + 16'h0001;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// settings pipeline, advanced only at frame boundaries

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (i = 0; i < NREG; i = i + 1) begin
        wr_q[i] <= reset_value(i);
        stage_q[i] <= reset_value(i);
        live_q[i] <= reset_value(i);
      end
    end else begin
      if (reg_we_i && wr_idx != I_NONE)
        wr_q[wr_idx] <= reg_wdata_i;
      if (frame_end) begin
        for (i = 0; i < NREG; i = i + 1) begin
          // a write on the boundary cycle still belongs to frame n
          if (reg_we_i && wr_idx == i[5:0])
            stage_q[i] <= reg_wdata_i;
          else
            stage_q[i] <= wr_q[i];
          live_q[i] <= stage_q[i];
        end
      end
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_re_i) begin
      if (reg_addr_i == `A_FRAME_COUNT)
        reg_rdata_o <= frame_cnt_q;
      else if (rd_idx != I_NONE)
        reg_rdata_o <= wr_q[rd_idx];
      else
        reg_rdata_o <= 16'h0000;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// serial framing codes

  wire [1:0] mode = live_q[33][1:0];
  reg [2:0] code_d;
  reg code_v_d;

  always @* begin
    code_d = 3'h0;
    code_v_d = 1'b0;
    if (col_q == 16'h0000) begin
      if (mode == `MODE_FRAMED && row_q == 16'h0000) begin
        code_d = `CODE_FRAME_START;
        code_v_d = 1'b1;
      end else if (mode == `MODE_PACKET && row_q == blank_rows) begin
        code_d = `CODE_FRAME_START;
        code_v_d = 1'b1;
      end
    end else if (col_q == 16'h0001) begin
      if (!in_active && (mode == `MODE_BASIC || mode == `MODE_FRAMED)) begin
        code_d = `CODE_BLANK_ROW;
        code_v_d = 1'b1;
      end else if (in_active && mode != `MODE_PARALLEL) begin
        code_d = `CODE_ROW_START;
        code_v_d = 1'b1;
      end
    end else if (mode == `MODE_PACKET && in_active) begin
      if (col_q == pix_end) begin
        code_d = `CODE_ROW_END;
        code_v_d = 1'b1;
      end else if (col_q == pix_end + 16'h0001 && last_row) begin
        code_d = `CODE_FRAME_END;
        code_v_d = 1'b1;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// pixel path: pedestal, then optional compander

  wire [12:0] ped_sum = {1'b0, pix_i} + {1'b0, live_q[32][11:0]};
  wire [11:0] ped_pix = ped_sum[12] ? 12'hFFF : ped_sum[11:0];
  // enable alone is not enough; the key guards against a half setup
  wire comp_on = live_q[34][0] && (live_q[35] == `COMPAND_KEY);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pix_o <= 12'h000;
      pix_valid_o <= 1'b0;
    end else begin
      pix_valid_o <= row_win_q;
      if (row_win_q) begin
        if (comp_on)
          pix_o <= {2'b00, compress(ped_pix)};
        else
          pix_o <= ped_pix;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// registered outputs

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_win_q <= 1'b0;
      row_window_flag_o <= 1'b0;
      frame_window_flag_o <= 1'b0;
      code_o <= 3'h0;
      code_valid_o <= 1'b0;
      frame_start_o <= 1'b0;
      exposure_rows_o <= 16'h0000;
      analog_gain_o <= 6'h00;
      gain_overall_o <= 16'h0000;
      context_o <= 1'b0;
      bin_o <= 2'b00;
    end else begin
      row_win_q <= row_win;
      row_window_flag_o <= row_win;
      frame_window_flag_o <= in_active;
      code_o <= code_d;
      code_valid_o <= code_v_d;
      frame_start_o <= (row_q == 16'h0000) && (col_q == 16'h0000);
      exposure_rows_o <= exposure;
      context_o <= ctx_live;
      gain_overall_o <= gain_all;
      if (ctx_live) begin
        analog_gain_o <= {gain_reg[13:12], gain_reg[11:8]};
        bin_o <= {bin_reg[`BIN_ROW_B], bin_reg[`BIN_COL_B]};
      end else begin
        analog_gain_o <= gain_reg[5:0];
        bin_o <= {bin_reg[`BIN_ROW_A], bin_reg[`BIN_COL_A]};
      end
    end
  end

endmodule // frame_readout_context_compand

// >>> inc/frame_readout_map.vh
// register offsets, reset values and code points of the frame readout block
`ifndef FRAME_READOUT_MAP_VH
`define FRAME_READOUT_MAP_VH
`define A_ROW_FIRST_A 16'h3002
`define A_COL_FIRST_A 16'h3004
`define A_ROW_LAST_A 16'h3006
`define A_COL_LAST_A 16'h3008
`define A_ROWS_PER_FRAME_A 16'h300A
`define A_CLOCKS_PER_ROW_A 16'h300C
`define A_EXPOSURE_ROWS_A 16'h3012
`define A_EXPOSURE_ROWS_B 16'h3016
`define A_CLOCKS_PER_ROW_B 16'h303E
`define A_BINNING_SELECT_AB 16'h3040
`define A_GAIN_GREEN_FIRST_A 16'h3056
`define A_GAIN_BLUE_A 16'h3058
`define A_GAIN_RED_A 16'h305A
`define A_GAIN_GREEN_SECOND_A 16'h305C
`define A_GAIN_OVERALL_A 16'h305E
`define A_ANALOG_GAIN_AB 16'h3060
`define A_COL_FIRST_B 16'h308A
`define A_ROW_FIRST_B 16'h308C
`define A_COL_LAST_B 16'h308E
`define A_ROW_LAST_B 16'h3090
`define A_COL_STEP_A 16'h30A2
`define A_ROW_STEP_A 16'h30A6
`define A_ROW_STEP_B 16'h30A8
`define A_ROWS_PER_FRAME_B 16'h30AA
`define A_COL_STEP_B 16'h30AE
`define A_GAIN_GREEN_FIRST_B 16'h30BC
`define A_GAIN_BLUE_B 16'h30BE
`define A_GAIN_RED_B 16'h30C0
`define A_GAIN_GREEN_SECOND_B 16'h30C2
`define A_GAIN_OVERALL_B 16'h30C4
`define A_CONTEXT_CTRL 16'h30B0
`define A_BLACK_ROWS 16'h3180
`define A_PEDESTAL 16'h30FE
`define A_FRAMING_MODE 16'h31E0
`define A_COMPAND_EN 16'h31D0
`define A_COMPAND_CFG 16'h31AC
`define A_FRAME_COUNT 16'h303A
`define CTX_BIT 13
`define BIN_ROW_A 12
`define BIN_COL_A 13
`define BIN_ROW_B 10
`define BIN_COL_B 11
`define BLACK_LSB 4
`define BLANK_EXTRA 16'h0008
`define COMPAND_KEY 16'h0C0A
`define RST_ROW_LAST 16'h02CF
`define RST_COL_LAST 16'h04FF
`define RST_STEP 16'h0001
`define RST_ROWS_PER_FRAME 16'h02EE
`define RST_CLOCKS_PER_ROW 16'h0672
`define RST_BLACK_ROWS 16'h0080
`define RST_EXPOSURE 16'h0010
`define MODE_PARALLEL 2'h0
`define MODE_BASIC 2'h1
`define MODE_FRAMED 2'h2
`define MODE_PACKET 2'h3
`define CODE_BLANK_ROW 3'h1
`define CODE_FRAME_START 3'h2
`define CODE_ROW_START 3'h3
`define CODE_ROW_END 3'h4
`define CODE_FRAME_END 3'h5
`define PIX_LEAD 16'h0002
`define ROW_TAIL 16'h0004
`endif

// >>> verif/stream_sink.sv
// camera processor model: frame timing and framing code counts
`timescale 1ns/1ps
module stream_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stream from the block
  input wire logic pix_valid_i,
  input wire logic frame_window_flag_i,
  input wire logic [2:0] code_i,
  input wire logic code_valid_i,
  input wire logic frame_start_i,
  // figures of the last whole frame
  output logic [39:0] period_o,
  output logic [39:0] lead_o,
  output logic [39:0] span_o,
  output logic [39:0] cnt_o
);
  logic [39:0] t_q, fw_q, first_q, last_q, c_q, inc;
  // one byte per code kind; in framed mode the frame-start code lands on the start cycle itself
  assign inc = (code_valid_i && code_i != 0 && code_i < 6) ? 40'h1 << (8 * code_i - 8) : '0;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {t_q, fw_q, first_q, last_q, c_q} <= '0;
      {period_o, lead_o, span_o, cnt_o} <= '0;
    end else if (frame_start_i) begin
      period_o <= t_q + 1;
      lead_o <= fw_q;
      span_o <= last_q - first_q;
      cnt_o <= c_q;
      {t_q, fw_q, first_q, last_q} <= '0;
      c_q <= inc;
    end else begin
      t_q <= t_q + 1;
      c_q <= c_q + inc;
      if (frame_window_flag_i && fw_q == 0) fw_q <= t_q + 1;
      if (pix_valid_i) last_q <= t_q + 1;
      if (pix_valid_i && first_q == 0) first_q <= t_q + 1;
    end
  end
endmodule // stream_sink

// >>> verif/frame_readout_properties.sv
// concurrent checks on the frame readout block outputs
`timescale 1ns/1ps
module frame_readout_properties (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // stream
  input wire pix_valid_o,
  input wire frame_window_flag_o,
  input wire row_window_flag_o,
  input wire [2:0] code_o,
  input wire code_valid_o,
  input wire frame_start_o,
  // settings in force
  input wire [15:0] exposure_rows_o,
  input wire [5:0] analog_gain_o,
  input wire [15:0] gain_overall_o,
  input wire context_o,
  input wire [1:0] bin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////
  a_valid_after_row: assert property (row_window_flag_o |=> pix_valid_o)
    else $error("pixel valid missing");
  a_valid_only_row: assert property (!row_window_flag_o |=> !pix_valid_o)
    else $error("stray pixel valid");
  a_row_in_frame: assert property (row_window_flag_o |-> frame_window_flag_o)
    else $error("row window outside frame window");
  a_code_known: assert property (code_valid_o |-> code_o inside {[3'h1:3'h5]})
    else $error("unknown framing code");
  a_code_off_pixels: assert property (row_window_flag_o |-> !code_valid_o)
    else $error("code during pixels");
  a_start_pulse: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start too long");
  a_blank_first: assert property (frame_start_o |-> !frame_window_flag_o)
    else $error("frame opens with active row");
  a_active_ends: assert property ($fell(frame_window_flag_o) |-> frame_start_o)
    else $error("active rows end before frame end");
  // one cycle of slack either side: pulse and settings may be staged apart
  a_settings_framed: assert property (
    $changed({context_o, analog_gain_o, gain_overall_o, bin_o})
      |-> $past(frame_start_o) or ##[0:1] frame_start_o)
    else $error("settings moved inside a frame");
  a_exposure_framed: assert property (
    $changed(exposure_rows_o) |-> $past(frame_start_o) or ##[0:1] frame_start_o)
    else $error("exposure moved inside a frame");
  c_frame: cover property (frame_start_o);
  c_frame_end: cover property (code_valid_o && code_o == 3'h5);
  c_context_b: cover property ($rose(context_o));
endmodule // frame_readout_properties
bind frame_readout_context_compand frame_readout_properties i_props (.*);

// >>> verif/testbench.sv
// self-checking bench for the frame readout block
`timescale 1ns/1ps
`include "frame_readout_map.vh"
module testbench;
  logic clk_i, rst_i, reg_we_i, reg_re_i, pix_valid_o, frame_window_flag_o;
  logic row_window_flag_o, code_valid_o, frame_start_o, context_o;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, exposure_rows_o, gain_overall_o;
  logic [11:0] pix_i, pix_o;
  logic [2:0] code_o;
  logic [5:0] analog_gain_o;
  logic [1:0] bin_o;
  logic [39:0] period, lead, span, cnt;
  int fails, n_tests;
  // A: 4 rows x 8 pixels, 24 rows of 16 clocks; B: same window, 40 rows
  logic [31:0] cfg [14] = '{32'h30060003, 32'h30080007, 32'h30900003, 32'h308E0007,
    32'h300A0018, 32'h300C0010, 32'h30AA0028, 32'h303E0010, 32'h305E0055,
    32'h30C400AA, 32'h30120003, 32'h30160007, 32'h30401800, 32'h30602315};
  // per mode {end frame, row end, row start, frame start, blank row}
  logic [39:0] codes [4] = '{40'h0, 40'h0000040014, 40'h0000040114, 40'h0104040100};
  logic [11:0] vals [10] = '{12'h0AB, 12'h0FF, 12'h100, 12'h1FF, 12'h200, 12'h3FF,
    12'h400, 12'h7FF, 12'h800, 12'hFFF};
  // short reset frame: 6 x 10 window, 32 rows of 20 clocks
  frame_readout_context_compand #(.RESET_ROW_LAST(16'h0005), .RESET_COL_LAST(16'h0009),
    .RESET_ROWS(16'h0020), .RESET_CLOCKS(16'h0014)) i_dut (.*);
  stream_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .pix_valid_i(pix_valid_o),
    .frame_window_flag_i(frame_window_flag_o), .code_i(code_o), .code_valid_i(code_valid_o),
    .frame_start_i(frame_start_o), .period_o(period), .lead_o(lead), .span_o(span),
    .cnt_o(cnt));
  ////////////////////////////////
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'h0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'h0;
    @(posedge clk_i);
    #1 chk(reg_rdata_o, e);
  endtask
  // bound covers the longest frame used (640 clocks)
  task wait_on(input logic pv, input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk_i);
        #1 k++;
        if (k > 1000) begin
          fails++;
          give_verdict();
        end
      end while ((pv ? pix_valid_o : frame_start_o) !== 1'h1);
    end
  endtask
  function automatic logic [11:0] law(input logic [11:0] x);
    if (x < 12'h100) return x;
    if (x < 12'h200) return {5'h02, x[7:1]};
    if (x < 12'h400) return {5'h03, x[8:2]};
    if (x < 12'h800) return {4'h2, x[9:2]};
    return {4'h3, x[10:3]};
  endfunction
  // new value set in blanking, so the first pixel of the frame carries it
  task pix_chk(input logic [11:0] v, input logic [11:0] e);
    wait_on(1'h0, 1);
    @(posedge clk_i) pix_i <= v;
    wait_on(1'h1, 1);
    chk(pix_o, e);
  endtask
  ////////////////////////////////
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i, pix_i} = {1'h1, 46'h0};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(`A_ROWS_PER_FRAME_A, 16'h0020);
    rd(`A_CLOCKS_PER_ROW_A, 16'h0014);
    rd(`A_COMPAND_EN, 16'h0000);
    rd(16'h3200, 16'h0000);
    foreach (cfg[i]) wr(cfg[i][31:16], cfg[i][15:0]);
    rd(`A_ROWS_PER_FRAME_A, 16'h0018);
    wait_on(1'h0, 1);
    chk({exposure_rows_o, gain_overall_o}, {`RST_EXPOSURE, 16'h0000});
    wait_on(1'h0, 1);
    chk({context_o, bin_o, analog_gain_o, gain_overall_o, exposure_rows_o},
      {1'h0, 2'h2, 6'h15, 16'h0055, 16'h0003});
    wait_on(1'h0, 1);
    @(posedge clk_i) #1 chk({period, lead, span}, {40'h180, 40'h140, 40'h37});
    wr(`A_CONTEXT_CTRL, 16'h2000);
    wait_on(1'h0, 1);
    chk({context_o, gain_overall_o, exposure_rows_o}, {1'h0, 16'h0055, 16'h0007});
    wait_on(1'h0, 1);
    chk({context_o, bin_o, analog_gain_o, gain_overall_o},
      {1'h1, 2'h1, 6'h23, 16'h00AA});
    wr(`A_CONTEXT_CTRL, 16'h0000);
    wait_on(1'h0, 1);
    @(posedge clk_i) #1 chk({period, lead, span}, {40'h280, 40'h240, 40'h37});
    chk({context_o, exposure_rows_o}, {1'h1, 16'h0003});
    wait_on(1'h0, 1);
    chk(context_o, 1'h0);
    for (int m = 0; m < 4; m++) begin
      wr(`A_FRAMING_MODE, 16'(m));
      wait_on(1'h0, 3);
      @(posedge clk_i) #1 chk(cnt, codes[m]);
    end
    pix_chk(12'hABC, 12'hABC);
    wr(`A_COMPAND_EN, 16'h0001);
    wr(`A_COMPAND_CFG, `COMPAND_KEY);
    wait_on(1'h0, 1);
    foreach (vals[i]) pix_chk(vals[i], law(vals[i]));
    wr(`A_PEDESTAL, 16'h00F0);
    wait_on(1'h0, 1);
    pix_chk(12'h110, law(12'h110 + 12'h0F0));
    // too few rows asked for: the frame grows to 2 active + 4 black + 8 rows
    wr(`A_BLACK_ROWS, 16'h0040);
    wr(`A_ROWS_PER_FRAME_A, 16'h0008);
    wr(`A_ROW_STEP_A, 16'h0003);
    wait_on(1'h0, 3);
    @(posedge clk_i) #1 chk({period, lead, span}, {40'hE0, 40'hC0, 40'h17});
    give_verdict();
  end
endmodule // testbench
